// ### rcsr_top.sv
// How it works
// - Correction byte, reset 2Ch, read/write
// - Bit 7 picks temperature source
// - Bits 6:0 factor, 100 ppm steps
// - Sense resistance scales with temperature above 25
// - Dead time word: high byte, low byte signed
// - Positive gap, negative overlap of drives
// - Frozen mode uses programmed once written, bounded by min/max
// - Freezing keeps dead time last in use
// - Dead time reset 1018h, range -15..60 ns
// - Bits 15 and 7 freeze each edge
// - Minimum fields, 2 ns units, adaptive floor
// - Mode register reset 8686h, both frozen
// - Prequel: enable needs request and power-good event
// - Sequel power-down event turns output off
// - Sequencing word field layout
// - Written sequencing word beats strap setting
// - Sequencing word reads back the strap setting after reset
// - Tracking enable bit 7, reset zero
// - Tracking bit 2 picks ratio
// - Tracking bit 1 picks upper limit
// - Tracking bit 0 allows early downward follow
// - Own rail identifier names this rail
`timescale 1ns/1ps
`default_nettype none
module rcsr_top (
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] CMD_CODE_I,
  input wire logic CMD_WR_I,
  input wire logic CMD_RD_I,
  input wire logic CMD_WORD_I,
  input wire logic [15:0] CMD_WDATA_I,
  output logic [15:0] CMD_RDATA_O,
  output logic CMD_ACK_O,
  output logic CMD_NACK_O,
  input wire logic signed [7:0] TEMP_C_I,
  input wire logic [15:0] CURRENT_SENSE_GAIN_I,
  output logic TEMP_SRC_EXT_O,
  output logic signed [33:0] SENSE_RESISTANCE_O,
  input wire logic signed [7:0] ADAPT_HL_NS_I,
  input wire logic signed [7:0] ADAPT_LH_NS_I,
  input wire rcsr_pkg::rcsr_dt_t MAX_NONOVERLAP_LIMIT_I,
  output rcsr_pkg::rcsr_dt_t NONOVERLAP_O,
  input wire logic ENABLE_PIN_I,
  input wire logic PIN_CTRL_I,
  input wire logic CMD_ON_I,
  input wire logic [4:0] RAIL_IDENTIFIER_I,
  input wire rcsr_pkg::rcsr_irb_evt_t INTER_RAIL_BUS_EVT_I,
  input wire logic [15:0] STRAP_ORDER_I,
  output logic RAIL_ENABLE_O,
  output logic SEQUEL_SHUTDOWN_O,
  output rcsr_pkg::rcsr_track_t FOLLOW_REFERENCE_INPUT_O
);

  logic [7:0] tcc_r;
  logic [15:0] times_r;
  logic [15:0] adapt_r;
  logic [15:0] order_r;
  logic order_written_r;
  logic [15:0] strap_r;
  logic strap_taken_r;
  logic [7:0] follow_r;
  logic [15:0] rdata_r;
  logic ack_r;
  logic nack_r;
  logic en_s1_r;
  logic en_s2_r;
  logic en_s3_r;
  logic en_pin_r;
  logic pre_good_r;
  logic pre_good_nxt;
  logic seq_down_r;
  logic seq_down_nxt;
  logic rail_en_r;
  logic signed [33:0] sres_r;
  logic load_prog_r;

  // Command decode
  wire logic hit_tcc = CMD_CODE_I == rcsr_pkg::CMD_THERMAL_COEF;
  wire logic hit_times = CMD_CODE_I == rcsr_pkg::CMD_NONOVERLAP_TIMES;
  wire logic hit_adapt = CMD_CODE_I == rcsr_pkg::CMD_NONOVERLAP_ADAPT;
  wire logic hit_order = CMD_CODE_I == rcsr_pkg::CMD_RAIL_ORDER;
  wire logic hit_follow = CMD_CODE_I == rcsr_pkg::CMD_VOLTAGE_FOLLOW;
  wire logic hit_byte = hit_tcc || hit_follow;
  wire logic hit_word = hit_times || hit_adapt || hit_order;
  // A write of the wrong size is refused rather than half applied
  wire logic size_ok = (hit_byte && !CMD_WORD_I) || (hit_word && CMD_WORD_I);
  wire logic wr_ok = CMD_WR_I && size_ok;
  wire logic rd_ok = CMD_RD_I && !CMD_WR_I && (hit_byte || hit_word);
  wire logic req = CMD_WR_I || CMD_RD_I;

  // Strap sequencing applies until software writes the word
  wire logic [15:0] order_eff = order_written_r ? order_r : strap_r;

  wire logic [15:0] rd_mux =
    hit_tcc ? {8'h00, tcc_r} :
    hit_times ? times_r :
    hit_adapt ? adapt_r :
    hit_order ? (order_eff & rcsr_pkg::RAIL_ORDER_MASK) :
    hit_follow ? {8'h00, follow_r & rcsr_pkg::VOLTAGE_FOLLOW_MASK} :
    16'h0000;

  // Write strobes, one per register; a refused write strobes nothing
  wire logic we_tcc = wr_ok && hit_tcc;
  wire logic we_times = wr_ok && hit_times;
  wire logic we_adapt = wr_ok && hit_adapt;
  wire logic we_order = wr_ok && hit_order;
  wire logic we_follow = wr_ok && hit_follow;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tcc_r <= rcsr_pkg::THERMAL_COEF_RST;
    end else if (we_tcc) begin
      tcc_r <= CMD_WDATA_I[7:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      times_r <= rcsr_pkg::NONOVERLAP_TIMES_RST;
    end else if (we_times) begin
      times_r <= CMD_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      adapt_r <= rcsr_pkg::NONOVERLAP_ADAPT_RST;
    end else if (we_adapt) begin
      adapt_r <= CMD_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      order_r <= rcsr_pkg::RAIL_ORDER_RST;
      order_written_r <= 1'b0;
    end else if (we_order) begin
      order_r <= CMD_WDATA_I & rcsr_pkg::RAIL_ORDER_MASK;
      order_written_r <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      follow_r <= rcsr_pkg::VOLTAGE_FOLLOW_RST;
    end else if (we_follow) begin
      follow_r <= CMD_WDATA_I[7:0] & rcsr_pkg::VOLTAGE_FOLLOW_MASK;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      ack_r <= wr_ok || rd_ok;
      nack_r <= req && !(wr_ok || rd_ok);
      if (rd_ok) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Strap caught on the first edge after reset release
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      strap_r <= 16'h0000;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_r <= STRAP_ORDER_I;
      strap_taken_r <= 1'b1;
    end
  end

  // Temperature correction: result in units of gain / 10000
  wire logic [6:0] tc_factor = tcc_r[rcsr_pkg::TC_FACTOR_MSB:0];
  wire logic signed [8:0] temp_delta = {TEMP_C_I[7], TEMP_C_I} - rcsr_pkg::T_REF_C;
  wire logic signed [17:0] tc_prod = 18'($signed({1'b0, tc_factor}) * temp_delta);
  wire logic signed [17:0] tc_scale = rcsr_pkg::TC_UNITY + tc_prod;
  wire logic signed [33:0] sres_nxt =
    34'($signed({1'b0, CURRENT_SENSE_GAIN_I}) * tc_scale);

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sres_r <= 34'sh0;
    end else begin
      sres_r <= sres_nxt;
    end
  end

  assign TEMP_SRC_EXT_O = tcc_r[rcsr_pkg::TC_SRC_BIT];
  assign SENSE_RESISTANCE_O = sres_r;

  // Dead time, one channel per switching edge; sign carries gap or overlap
  // Reload one edge after the write, once the register already holds the new word
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      load_prog_r <= 1'b0;
    end else begin
      load_prog_r <= we_times;
    end
  end

  rcsr_dt_edge #(
    .RST_NS(rcsr_pkg::NONOVERLAP_TIMES_RST[15:8])
  ) u_dt_hl (
    .clk_i(CLOCK_I),
    .rst_n_i(ARST_N_I),
    .freeze_i(adapt_r[rcsr_pkg::ADAPT_HL_FREEZE_BIT]),
    .load_i(load_prog_r),
    .prog_i(times_r[15:8]),
    .min_field_i(adapt_r[rcsr_pkg::ADAPT_HL_MIN_LSB +: 7]),
    .max_i(MAX_NONOVERLAP_LIMIT_I.hl),
    .adapt_i(ADAPT_HL_NS_I),
    .dt_o(NONOVERLAP_O.hl)
  );

  rcsr_dt_edge #(
    .RST_NS(rcsr_pkg::NONOVERLAP_TIMES_RST[7:0])
  ) u_dt_lh (
    .clk_i(CLOCK_I),
    .rst_n_i(ARST_N_I),
    .freeze_i(adapt_r[rcsr_pkg::ADAPT_LH_FREEZE_BIT]),
    .load_i(load_prog_r),
    .prog_i(times_r[7:0]),
    .min_field_i(adapt_r[rcsr_pkg::ADAPT_LH_MIN_LSB +: 7]),
    .max_i(MAX_NONOVERLAP_LIMIT_I.lh),
    .adapt_i(ADAPT_LH_NS_I),
    .dt_o(NONOVERLAP_O.lh)
  );

  // Enable pin: three stages, level taken once the last two agree
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      en_s3_r <= 1'b0;
      en_pin_r <= 1'b0;
    end else begin
      en_s1_r <= ENABLE_PIN_I;
      en_s2_r <= en_s1_r;
      en_s3_r <= en_s2_r;
      if (en_s2_r == en_s3_r) begin
        en_pin_r <= en_s3_r;
      end
    end
  end

  wire logic en_state = PIN_CTRL_I ? en_pin_r : CMD_ON_I;

  // Sequencing fields
  wire logic pre_en = order_eff[rcsr_pkg::PRE_EN_BIT];
  wire logic [4:0] pre_id = order_eff[rcsr_pkg::PRE_ID_LSB +: 5];
  wire logic seq_en = order_eff[rcsr_pkg::SEQ_EN_BIT];
  wire logic [4:0] seq_id = order_eff[rcsr_pkg::SEQ_ID_LSB +: 5];

  // Own broadcasts are never taken as a neighbour's events
  wire logic evt_foreign = INTER_RAIL_BUS_EVT_I.valid &&
                           (INTER_RAIL_BUS_EVT_I.id != RAIL_IDENTIFIER_I);
  wire logic pre_match = evt_foreign && (INTER_RAIL_BUS_EVT_I.id == pre_id);
  wire logic seq_match = evt_foreign && (INTER_RAIL_BUS_EVT_I.id == seq_id);

  // Set wins when both arrive together
  function automatic logic flag_upd(input logic hit, input logic set, input logic clr,
                                    input logic cur);
    if (hit && set) begin
      flag_upd = 1'b1;
    end else if (hit && clr) begin
      flag_upd = 1'b0;
    end else begin
      flag_upd = cur;
    end
  endfunction

  assign pre_good_nxt = flag_upd(pre_match, INTER_RAIL_BUS_EVT_I.pgood,
                                 INTER_RAIL_BUS_EVT_I.pdown, pre_good_r);
  assign seq_down_nxt = flag_upd(seq_match, INTER_RAIL_BUS_EVT_I.pdown,
                                 INTER_RAIL_BUS_EVT_I.pgood, seq_down_r);

  wire logic shut_req = seq_en && seq_down_r;
  wire logic rail_en_nxt = en_state && (!pre_en || pre_good_r) && !shut_req;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pre_good_r <= 1'b0;
      seq_down_r <= 1'b0;
      rail_en_r <= 1'b0;
    end else begin
      pre_good_r <= pre_good_nxt;
      seq_down_r <= seq_down_nxt;
      rail_en_r <= rail_en_nxt;
    end
  end

  assign RAIL_ENABLE_O = rail_en_r;
  assign SEQUEL_SHUTDOWN_O = shut_req;

  // Tracking controls straight from the stored byte
  assign FOLLOW_REFERENCE_INPUT_O.en = follow_r[rcsr_pkg::FOLLOW_EN_BIT];
  assign FOLLOW_REFERENCE_INPUT_O.half_ratio = follow_r[rcsr_pkg::FOLLOW_HALF_BIT];
  assign FOLLOW_REFERENCE_INPUT_O.limit_ref = follow_r[rcsr_pkg::FOLLOW_LIMIT_BIT];
  assign FOLLOW_REFERENCE_INPUT_O.track_always = follow_r[rcsr_pkg::FOLLOW_ALWAYS_BIT];

  assign CMD_RDATA_O = rdata_r;
  assign CMD_ACK_O = ack_r;
  assign CMD_NACK_O = nack_r;

endmodule
`default_nettype wire

// ### rcsr_pkg.sv
`default_nettype none
package rcsr_pkg;

  // Command codes
  localparam logic [7:0] CMD_THERMAL_COEF = 8'hDC;
  localparam logic [7:0] CMD_NONOVERLAP_TIMES = 8'hDD;
  localparam logic [7:0] CMD_NONOVERLAP_ADAPT = 8'hDE;
  localparam logic [7:0] CMD_RAIL_ORDER = 8'hE0;
  localparam logic [7:0] CMD_VOLTAGE_FOLLOW = 8'hE1;

  // Reset values
  localparam logic [7:0] THERMAL_COEF_RST = 8'h2C;
  localparam logic [15:0] NONOVERLAP_TIMES_RST = 16'h1018;
  localparam logic [15:0] NONOVERLAP_ADAPT_RST = 16'h8686;
  localparam logic [15:0] RAIL_ORDER_RST = 16'h0000;
  localparam logic [7:0] VOLTAGE_FOLLOW_RST = 8'h00;

  // Writable bit masks, reserved bits are zero
  localparam logic [15:0] RAIL_ORDER_MASK = 16'h9F9F;
  localparam logic [7:0] VOLTAGE_FOLLOW_MASK = 8'h87;

  // Field positions
  localparam int TC_SRC_BIT = 7;
  localparam int TC_FACTOR_MSB = 6;
  localparam int ADAPT_HL_FREEZE_BIT = 15;
  localparam int ADAPT_HL_MIN_LSB = 8;
  localparam int ADAPT_LH_FREEZE_BIT = 7;
  localparam int ADAPT_LH_MIN_LSB = 0;
  localparam int PRE_EN_BIT = 15;
  localparam int PRE_ID_LSB = 8;
  localparam int SEQ_EN_BIT = 7;
  localparam int SEQ_ID_LSB = 0;
  localparam int FOLLOW_EN_BIT = 7;
  localparam int FOLLOW_HALF_BIT = 2;
  localparam int FOLLOW_LIMIT_BIT = 1;
  localparam int FOLLOW_ALWAYS_BIT = 0;

  // Dead time limits in ns, and current sense scaling
  localparam logic signed [8:0] DT_RANGE_MIN_NS = -9'sd15;
  localparam logic signed [8:0] DT_RANGE_MAX_NS = 9'sd60;
  localparam logic signed [17:0] TC_UNITY = 18'sd10000;
  localparam logic signed [8:0] T_REF_C = 9'sd25;

  typedef struct packed {
    logic signed [7:0] hl;
    logic signed [7:0] lh;
  } rcsr_dt_t;

  typedef struct packed {
    logic en;
    logic half_ratio;
    logic limit_ref;
    logic track_always;
  } rcsr_track_t;

  typedef struct packed {
    logic valid;
    logic pgood;
    logic pdown;
    logic [4:0] id;
  } rcsr_irb_evt_t;

endpackage
`default_nettype wire

// ### rcsr_dt_edge.sv
`timescale 1ns/1ps
`default_nettype none
module rcsr_dt_edge #(
  parameter logic signed [7:0] RST_NS = 8'sh10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic freeze_i,
  input wire logic load_i,
  input wire logic signed [7:0] prog_i,
  input wire logic [6:0] min_field_i,
  input wire logic signed [7:0] max_i,
  input wire logic signed [7:0] adapt_i,
  output logic signed [7:0] dt_o
);

  logic signed [7:0] dt_r;
  logic signed [7:0] dt_nxt;

  // Upper bound last, so the result always fits the signed byte
  function automatic logic signed [7:0] dt_limit(input logic signed [7:0] v,
                                                input logic [6:0] min_f,
                                                input logic signed [7:0] max_v);
    logic signed [8:0] w;
    logic signed [8:0] lo;
    logic signed [8:0] hi;
    w = {v[7], v};
    lo = $signed({1'b0, min_f[6:0], 1'b0}) > rcsr_pkg::DT_RANGE_MIN_NS ?
         $signed({1'b0, min_f[6:0], 1'b0}) : rcsr_pkg::DT_RANGE_MIN_NS;
    hi = $signed({max_v[7], max_v}) < rcsr_pkg::DT_RANGE_MAX_NS ?
         $signed({max_v[7], max_v}) : rcsr_pkg::DT_RANGE_MAX_NS;
    if (w < lo) begin
      w = lo;
    end
    if (w > hi) begin
      w = hi;
    end
    dt_limit = w[7:0];
  endfunction

  wire logic signed [7:0] adapt_lim = dt_limit(adapt_i, min_field_i, max_i);
  wire logic signed [7:0] prog_lim = dt_limit(prog_i, min_field_i, max_i);

  // Freezing keeps the value last in use; only a new program reloads it
  assign dt_nxt = !freeze_i ? adapt_lim : (load_i ? prog_lim : dt_r);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dt_r <= RST_NS;
    end else begin
      dt_r <= dt_nxt;
    end
  end

  assign dt_o = dt_r;

endmodule
`default_nettype wire

// ### rcsr_peer_rail.sv
`timescale 1ns/1ps
`default_nettype none
module rcsr_peer_rail (
  input wire logic clk_i,
  output var rcsr_pkg::rcsr_irb_evt_t evt_o
);
  initial evt_o = '0;
  // Idle fields show the inverse so a decoder that ignores valid is caught
  task automatic send(input logic pg, input logic pd, input logic [4:0] id);
    @(negedge clk_i);
    evt_o = {1'b1, pg, pd, id};
    @(negedge clk_i);
    evt_o = {1'b0, ~pg, ~pd, ~id};
  endtask
endmodule
`default_nettype wire

// ### rcsr_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rcsr_top_chk (
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] CMD_CODE_I,
  input wire logic CMD_WR_I,
  input wire logic CMD_RD_I,
  input wire logic CMD_WORD_I,
  input wire logic [15:0] CMD_WDATA_I,
  input wire logic [15:0] CMD_RDATA_O,
  input wire logic CMD_ACK_O,
  input wire logic CMD_NACK_O,
  input wire logic TEMP_SRC_EXT_O,
  input wire rcsr_pkg::rcsr_dt_t NONOVERLAP_O,
  input wire logic PIN_CTRL_I,
  input wire logic CMD_ON_I,
  input wire logic RAIL_ENABLE_O,
  input wire logic SEQUEL_SHUTDOWN_O,
  input wire rcsr_pkg::rcsr_track_t FOLLOW_REFERENCE_INPUT_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_rd(c);
    CMD_RD_I && !CMD_WR_I && CMD_CODE_I == c;
  endsequence
  sequence s_wr(c, w);
    CMD_WR_I && CMD_CODE_I == c && CMD_WORD_I == w;
  endsequence
  property p_refuse;
    s_wr(8'hDD, 1'b0) |=> CMD_NACK_O && !CMD_ACK_O;
  endproperty
  a_refuse: assert property (p_refuse) else $error("byte write to word reg accepted");
  property p_ack_e0;
    s_rd(8'hE0) |=> CMD_ACK_O && !CMD_NACK_O;
  endproperty
  a_ack_e0: assert property (p_ack_e0) else $error("order read not acked");
  property p_rsv_e0;
    s_rd(8'hE0) |=> (CMD_RDATA_O & 16'h6060) == 16'h0000;
  endproperty
  a_rsv_e0: assert property (p_rsv_e0) else $error("reserved order bits set");
  property p_follow;
    s_wr(8'hE1, 1'b0) |=>
      FOLLOW_REFERENCE_INPUT_O == {$past(CMD_WDATA_I[7]), $past(CMD_WDATA_I[2:0])};
  endproperty
  a_follow: assert property (p_follow) else $error("tracking outputs wrong");
  property p_tsrc;
    s_wr(8'hDC, 1'b0) |=> TEMP_SRC_EXT_O == $past(CMD_WDATA_I[7]);
  endproperty
  a_tsrc: assert property (p_tsrc) else $error("temp source wrong");
  property p_off;
    !PIN_CTRL_I && !CMD_ON_I |=> !RAIL_ENABLE_O;
  endproperty
  a_off: assert property (p_off) else $error("enabled without enable state");
  property p_seq;
    SEQUEL_SHUTDOWN_O |=> !RAIL_ENABLE_O;
  endproperty
  a_seq: assert property (p_seq) else $error("enabled during sequel shutdown");
  property p_range;
    NONOVERLAP_O.hl >= -8'sd15 && NONOVERLAP_O.hl <= 8'sd60 &&
      NONOVERLAP_O.lh >= -8'sd15 && NONOVERLAP_O.lh <= 8'sd60;
  endproperty
  a_range: assert property (p_range) else $error("dead time out of range");
endmodule
bind rcsr_top rcsr_top_chk u_rcsr_top_chk (.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I),
  .CMD_CODE_I(CMD_CODE_I), .CMD_WR_I(CMD_WR_I), .CMD_RD_I(CMD_RD_I),
  .CMD_WORD_I(CMD_WORD_I), .CMD_WDATA_I(CMD_WDATA_I), .CMD_RDATA_O(CMD_RDATA_O),
  .CMD_ACK_O(CMD_ACK_O), .CMD_NACK_O(CMD_NACK_O), .TEMP_SRC_EXT_O(TEMP_SRC_EXT_O),
  .NONOVERLAP_O(NONOVERLAP_O), .PIN_CTRL_I(PIN_CTRL_I), .CMD_ON_I(CMD_ON_I),
  .RAIL_ENABLE_O(RAIL_ENABLE_O), .SEQUEL_SHUTDOWN_O(SEQUEL_SHUTDOWN_O),
  .FOLLOW_REFERENCE_INPUT_O(FOLLOW_REFERENCE_INPUT_O));
`default_nettype wire

// ### rcsr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rcsr_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] code = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wd = 1'b0;
  logic on = 1'b0;
  logic pin = 1'b0;
  logic pin_ctl = 1'b0;
  logic [15:0] wdat = 16'h0000;
  logic signed [7:0] a_hl = 8'sd0;
  logic signed [7:0] a_lh = 8'sd0;
  rcsr_pkg::rcsr_dt_t mx = 16'h3C3C;
  logic [15:0] rdat;
  logic ack, nack, tsrc, ren, sdn;
  logic signed [33:0] sres;
  rcsr_pkg::rcsr_dt_t dt;
  rcsr_pkg::rcsr_irb_evt_t evt;
  rcsr_pkg::rcsr_track_t trk;
  int mismatches = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  // Strap asks for a prequel, so the rail stays off until a power-good event arrives from the prequel rail
  rcsr_top u_rcsr_top (.CLOCK_I(clk), .ARST_N_I(rst_n), .CMD_CODE_I(code), .CMD_WR_I(wr),
    .CMD_RD_I(rd), .CMD_WORD_I(wd), .CMD_WDATA_I(wdat), .CMD_RDATA_O(rdat), .CMD_ACK_O(ack),
    .CMD_NACK_O(nack), .TEMP_C_I(8'sd35), .CURRENT_SENSE_GAIN_I(16'h0003),
    .TEMP_SRC_EXT_O(tsrc), .SENSE_RESISTANCE_O(sres), .ADAPT_HL_NS_I(a_hl),
    .ADAPT_LH_NS_I(a_lh), .MAX_NONOVERLAP_LIMIT_I(mx), .NONOVERLAP_O(dt),
    .ENABLE_PIN_I(pin), .PIN_CTRL_I(pin_ctl), .CMD_ON_I(on), .RAIL_IDENTIFIER_I(5'h07),
    .INTER_RAIL_BUS_EVT_I(evt), .STRAP_ORDER_I(16'h8A00), .RAIL_ENABLE_O(ren),
    .SEQUEL_SHUTDOWN_O(sdn), .FOLLOW_REFERENCE_INPUT_O(trk));
  rcsr_peer_rail u_rcsr_peer_rail (.clk_i(clk), .evt_o(evt));
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Answer stands one cycle, so it is read at the falling edge after the request
  task automatic acc(input logic w, input logic [7:0] c, input logic s, input logic [15:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    code = c;
    wd = s;
    wdat = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic wrc(input logic [7:0] c, input logic s, input logic [15:0] d);
    acc(1'b1, c, s, d);
    chk(ack, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    acc(1'b0, c, 1'b0, 16'h0000);
    chk({ack, rdat}, {1'b1, e});
  endtask
  task automatic t_reset;
    rdc(8'hDC, 16'h002C);
    rdc(8'hDD, 16'h1018);
    rdc(8'hDE, 16'h8686);
    rdc(8'hE0, 16'h8A00);
    rdc(8'hE1, 16'h0000);
    chk(dt, 16'h1018);
    chk(sres, 34'd31320);
    chk(tsrc, 1'b0);
    $display("TB: test reset done");
  endtask
  task automatic t_regs;
    wrc(8'hDC, 1'b0, 16'h00AB);
    cyc(2);
    chk(tsrc, 1'b1);
    chk(sres, 34'd31290);
    rdc(8'hDC, 16'h00AB);
    wrc(8'hE1, 1'b0, 16'h00FF);
    rdc(8'hE1, 16'h0087);
    chk(trk, 4'hF);
    wrc(8'hE1, 1'b0, 16'h0005);
    chk(trk, 4'h5);
    wrc(8'hE1, 1'b0, 16'h0002);
    chk(trk, 4'h2);
    acc(1'b1, 8'hDC, 1'b1, 16'h0055);
    chk({ack, nack}, 2'b01);
    rdc(8'hDC, 16'h00AB);
    acc(1'b1, 8'hDD, 1'b0, 16'h0055);
    chk({ack, nack}, 2'b01);
    acc(1'b0, 8'h55, 1'b0, 16'h0000);
    chk({ack, nack}, 2'b01);
    $display("TB: test registers done");
  endtask
  task automatic t_dt;
    a_hl = 8'sd70;
    a_lh = -8'sd20;
    wrc(8'hDE, 1'b1, 16'h0000);
    cyc(3);
    chk(dt, 16'h3C00);
    wrc(8'hDE, 1'b1, 16'h0A00);
    a_hl = 8'sd5;
    cyc(3);
    chk(dt, 16'h1400);
    a_hl = 8'sd30;
    cyc(3);
    chk(dt, 16'h1E00);
    wrc(8'hDE, 1'b1, 16'h8080);
    a_hl = 8'sd40;
    cyc(3);
    chk(dt, 16'h1E00);
    mx = 16'h323C;
    wrc(8'hDD, 1'b1, 16'h4605);
    cyc(2);
    chk(dt, 16'h3205);
    rdc(8'hDD, 16'h4605);
    $display("TB: test dead time done");
  endtask
  task automatic t_seq;
    on = 1'b1;
    cyc(4);
    chk(ren, 1'b0);
    wrc(8'hE0, 1'b1, 16'hE385);
    rdc(8'hE0, 16'h8385);
    cyc(3);
    chk(ren, 1'b0);
    u_rcsr_peer_rail.send(1'b1, 1'b0, 5'h03);
    cyc(2);
    chk(ren, 1'b1);
    u_rcsr_peer_rail.send(1'b0, 1'b1, 5'h05);
    cyc(2);
    chk({sdn, ren}, 2'b10);
    on = 1'b0;
    $display("TB: test sequencing done");
  endtask
  // Pin path goes through the synchroniser, so its effect lags by several edges
  task automatic t_pin;
    wrc(8'hE0, 1'b1, 16'h0000);
    pin_ctl = 1'b1;
    on = 1'b1;
    cyc(3);
    chk(ren, 1'b0);
    pin = 1'b1;
    cyc(2);
    chk(ren, 1'b0);
    cyc(4);
    chk(ren, 1'b1);
    wrc(8'hE0, 1'b1, 16'h8300);
    u_rcsr_peer_rail.send(1'b0, 1'b1, 5'h03);
    cyc(2);
    chk(ren, 1'b0);
    wrc(8'hE0, 1'b1, 16'h8700);
    u_rcsr_peer_rail.send(1'b1, 1'b0, 5'h07);
    cyc(2);
    chk(ren, 1'b0);
    wrc(8'hE0, 1'b1, 16'h0000);
    cyc(1);
    chk(ren, 1'b1);
    pin = 1'b0;
    cyc(2);
    chk(ren, 1'b1);
    cyc(4);
    chk(ren, 1'b0);
    on = 1'b0;
    pin_ctl = 1'b0;
    $display("TB: test enable pin done");
  endtask
  task automatic report_and_stop;
    $display("TB: %0d checked, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_dt;
    t_seq;
    t_pin;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
